// ---- rtl/apwr_ctrl.sv ----
// adc power status word and power option word behind an avalon-mm slave
// assumes analog power-down levels and sleep context come from other clock
// domains or pads, and that the bus master sits on i_clock
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "apwr_defs.svh"

module apwr_ctrl (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [31:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic o_readdatavalid,
  // analog power-down levels from the adc chain
  input wire apwr_pkg::apwr_status_t i_analog_off,
  // sleep context
  input wire apwr_pkg::apwr_context_t i_context,
  // regulator and adc power controls
  output apwr_pkg::apwr_control_t o_control,
  output apwr_pkg::apwr_option_t o_option
);

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  apwr_pkg::apwr_status_t st_meta_r;
  apwr_pkg::apwr_status_t st_sync_r;
  apwr_pkg::apwr_context_t ctx_meta_r;
  apwr_pkg::apwr_context_t ctx_sync_r;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_meta_r <= '0;
      st_sync_r <= '0;
      ctx_meta_r <= '0;
      ctx_sync_r <= '0;
    end else begin
      st_meta_r <= i_analog_off;
      st_sync_r <= st_meta_r;
      ctx_meta_r <= i_context;
      ctx_sync_r <= ctx_meta_r;
    end
  end

  // ----------------------------------------------------------------------
  // status word image
  // ----------------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h00000000;
    status_word[`APWR_ST_CONV_BIT] = st_sync_r.converter_off_flag;
    status_word[`APWR_ST_BANDGAP_BIT] = st_sync_r.bandgap_off_flag;
    status_word[`APWR_ST_TEMPBUF_BIT] = st_sync_r.temp_sensor_buffer_off_flag;
    status_word[`APWR_ST_BATDIV_BIT] = st_sync_r.battery_divider_off_flag;
    status_word[`APWR_ST_KEEPER_BIT] = st_sync_r.reference_keeper_off_flag;
    status_word[`APWR_ST_REFBUF_BIT] = st_sync_r.reference_buffer_off_flag;
  end

  // ----------------------------------------------------------------------
  // bus slave: one wait cycle, answer on the second edge
  // ----------------------------------------------------------------------
  apwr_pkg::apwr_bus_state_t state_r;
  apwr_pkg::apwr_bus_state_t state_nxt;
  apwr_pkg::apwr_option_t option_r;
  apwr_pkg::apwr_option_t option_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic hit_status;
  logic hit_option;
  logic [31:0] read_mux;

  always_comb begin
    hit_status = 1'b0;
    hit_option = 1'b0;
    if (i_address == (`APWR_BASE_ADDR + `APWR_OPTION_OFS)) begin
      hit_option = 1'b1;
    end else if (i_address == (`APWR_BASE_ADDR + `APWR_ADC_STATUS_OFS)) begin
      hit_status = 1'b1;
    end
  end

  always_comb begin
    read_mux = `APWR_UNMAPPED_DATA;
    if (hit_option) begin
      read_mux = {29'h0, option_r};
    end else if (hit_status) begin
      read_mux = status_word;
    end
  end

  always_comb begin
    state_nxt = state_r;
    option_nxt = option_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    case (state_r)
      apwr_pkg::APWR_IDLE: begin
        if (i_read || i_write) begin
          state_nxt = apwr_pkg::APWR_ANSWER;
        end
        // capture read data so it stands from a flop in the answer cycle
        if (i_read) begin
          rdata_nxt = read_mux;
        end
      end
      apwr_pkg::APWR_ANSWER: begin
        state_nxt = apwr_pkg::APWR_IDLE;
        if (i_read) begin
          rvalid_nxt = 1'b1;
        end else if (i_write && hit_option && i_byteenable[0]) begin
          option_nxt = i_writedata[`APWR_OPT_WIDTH-1:0];
        end
      end
      default: begin
        state_nxt = apwr_pkg::APWR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r <= apwr_pkg::APWR_IDLE;
      option_r <= `APWR_OPT_RESET;
      rdata_r <= 32'h00000000;
      rvalid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      option_r <= option_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // read data registered in the wait cycle, standing at the accepting edge
  assign o_waitrequest = !(state_r == apwr_pkg::APWR_ANSWER);
  assign o_readdata = rdata_r;
  assign o_readdatavalid = rvalid_r;
  assign o_option = option_r;

  // ----------------------------------------------------------------------
  // power decisions
  // ----------------------------------------------------------------------
  apwr_pkg::apwr_control_t ctl_r;
  apwr_pkg::apwr_control_t ctl_nxt;

  always_comb begin
    ctl_nxt = '0;
    ctl_nxt.adc_power_down = ctx_sync_r.adc_idle &&
      (option_r.adc_enable_mask || !ctx_sync_r.adc_enable);
    ctl_nxt.mem_regulator_low_power_state = ctx_sync_r.deep_sleep &&
      (!ctx_sync_r.timers_running ||
       option_r.mem_regulator_lowpower_with_timers);
    ctl_nxt.core_regulator_low_power_state = ctx_sync_r.deep_sleep &&
      (!ctx_sync_r.fast_rc_oscillator ||
       option_r.core_regulator_lowpower_with_fast_osc);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctl_r <= '0;
    end else begin
      ctl_r <= ctl_nxt;
    end
  end

  assign o_control = ctl_r;

endmodule // apwr_ctrl

// ---- rtl/apwr_defs.svh ----
// register offsets, field positions and reset values for the adc power
// status and power option slice; assumes avalon-mm byte addressing
`ifndef APWR_DEFS_SVH
`define APWR_DEFS_SVH

// ----------------------------------------------------------------------
// addresses
// ----------------------------------------------------------------------
`define APWR_BASE_ADDR 32'h40021000
`define APWR_ADC_STATUS_OFS 32'h0000001c
`define APWR_OPTION_OFS 32'h00000020

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define APWR_ST_CONV_BIT 0
`define APWR_ST_BANDGAP_BIT 1
`define APWR_ST_TEMPBUF_BIT 2
`define APWR_ST_BATDIV_BIT 3
`define APWR_ST_KEEPER_BIT 4
`define APWR_ST_REFBUF_BIT 5
`define APWR_ST_WIDTH 6
`define APWR_ST_RESET 6'h00

// ----------------------------------------------------------------------
// option fields
// ----------------------------------------------------------------------
`define APWR_OPT_ENMASK_BIT 0
`define APWR_OPT_COREFAST_BIT 1
`define APWR_OPT_MEMTIMER_BIT 2
`define APWR_OPT_WIDTH 3
`define APWR_OPT_RESET 3'h0

`define APWR_UNMAPPED_DATA 32'h00000000

`endif

// ---- rtl/apwr_pkg.sv ----
// types for the adc power status and power option slice
// assumes apwr_defs.svh supplies the field widths
`include "apwr_defs.svh"

package apwr_pkg;

  // ----------------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic reference_buffer_off_flag;
    logic reference_keeper_off_flag;
    logic battery_divider_off_flag;
    logic temp_sensor_buffer_off_flag;
    logic bandgap_off_flag;
    logic converter_off_flag;
  } apwr_status_t;

  typedef struct packed {
    logic mem_regulator_lowpower_with_timers;
    logic core_regulator_lowpower_with_fast_osc;
    logic adc_enable_mask;
  } apwr_option_t;

  // ----------------------------------------------------------------------
  // analog requests and sleep context
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic deep_sleep;
    logic timers_running;
    logic fast_rc_oscillator;
    logic adc_enable;
    logic adc_idle;
  } apwr_context_t;

  typedef struct packed {
    logic mem_regulator_low_power_state;
    logic core_regulator_low_power_state;
    logic adc_power_down;
  } apwr_control_t;

  typedef enum logic [1:0] {
    APWR_IDLE,
    APWR_ANSWER
  } apwr_bus_state_t;

endpackage

// ---- test/apwr_chk.sv ----
// assertions for the adc power slice, seen at the top-level ports
// assumes byte addresses from apwr_defs.svh
`timescale 1ns/1ps
`include "apwr_defs.svh"
module apwr_chk (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [31:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_readdatavalid,
  input wire apwr_pkg::apwr_status_t i_analog_off,
  input wire apwr_pkg::apwr_context_t i_context,
  input wire apwr_pkg::apwr_control_t o_control,
  input wire apwr_pkg::apwr_option_t o_option
);
  localparam logic [31:0] OA = `APWR_BASE_ADDR + `APWR_OPTION_OFS;
  localparam logic [31:0] SA = `APWR_BASE_ADDR + `APWR_ADC_STATUS_OFS;
  logic rd;
  logic wo;
  logic [2:0] ce;
  assign rd = i_read && !o_waitrequest;
  assign wo = i_write && !o_waitrequest && i_address == OA && i_byteenable[0];
  assign ce = {i_context.deep_sleep && (!i_context.timers_running ||
    o_option[2]), i_context.deep_sleep && (!i_context.fast_rc_oscillator
    || o_option[1]), i_context.adc_idle && (o_option[0] ||
    !i_context.adc_enable)};
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence quiet;
    $stable(i_context) && $stable(o_option);
  endsequence
  a_wait_answer: assert property ((i_read || i_write) && o_waitrequest
    |=> !o_waitrequest) else $error("no answer after one wait cycle");
  a_wait_one: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_rdvalid_pulse: assert property (rd |=> o_readdatavalid)
    else $error("read data valid pulse missing");
  a_opt_write: assert property (wo |=>
    o_option == $past(i_writedata[2:0]))
    else $error("option word not written");
  a_opt_hold: assert property (!wo |=> $stable(o_option))
    else $error("option word changed without a write");
  a_opt_read: assert property (rd && i_address == OA
    |-> o_readdata == {29'h0, o_option}) else $error("option read wrong");
  a_status_read: assert property (
    $stable(i_analog_off)[*3] ##0 rd &&
    i_address == SA |-> o_readdata == {26'h0, i_analog_off})
    else $error("status read wrong");
  a_unmapped_zero: assert property (rd && i_address != OA &&
    i_address != SA |-> o_readdata == 32'h0) else $error("unmapped read");
  a_control_eqn: assert property (quiet[*4] |-> o_control == ce)
    else $error("regulator or adc control wrong");
  c_status: cover property (rd && i_address == SA);
  c_optwr: cover property (wo);
  c_adcoff: cover property (o_control.adc_power_down);
endmodule // apwr_chk
bind apwr_ctrl apwr_chk apwr_chk_inst (.i_clock(i_clock), .i_rst(i_rst),
  .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .i_writedata(i_writedata), .i_byteenable(i_byteenable),
  .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_readdatavalid(o_readdatavalid), .i_analog_off(i_analog_off),
  .i_context(i_context), .o_control(o_control), .o_option(o_option));

// ---- test/tb_top.sv ----
// self-checking bench for the adc power status and option slice
// assumes one avalon master and one clock
`timescale 1ns/1ps
`include "apwr_defs.svh"
module tb_top;
  localparam logic [31:0] OA = `APWR_BASE_ADDR + `APWR_OPTION_OFS;
  localparam logic [31:0] SA = `APWR_BASE_ADDR + `APWR_ADC_STATUS_OFS;
  logic i_clock, i_rst, i_read, i_write, o_waitrequest, o_readdatavalid;
  logic [31:0] i_address, i_writedata, o_readdata, q;
  logic [3:0] i_byteenable;
  logic [2:0] ce;
  apwr_pkg::apwr_status_t i_analog_off;
  apwr_pkg::apwr_context_t i_context;
  apwr_pkg::apwr_control_t o_control;
  apwr_pkg::apwr_option_t o_option;
  int miscompares = 0;
  int checks = 0;
  apwr_ctrl apwr_ctrl_inst (.i_clock(i_clock), .i_rst(i_rst),
    .i_address(i_address), .i_read(i_read), .i_write(i_write),
    .i_writedata(i_writedata), .i_byteenable(i_byteenable),
    .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_readdatavalid(o_readdatavalid), .i_analog_off(i_analog_off),
    .i_context(i_context), .o_control(o_control), .o_option(o_option));
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // hold the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
    if (n >= 50) miscompares++;
  endtask
  task automatic t_regs();
    bus(0, OA, 32'h0);
    chk("option reset", 32'h0, q);
    for (int k = 0; k < 7; k++) begin
      @(posedge i_clock);
      i_analog_off <= (k == 6) ? 6'h3f : 6'h01 << k;
      bus(1, SA, 32'h0);
      bus(0, SA, 32'h0);
      chk("status", (k == 6) ? 32'h3f : 32'h1 << k, q);
    end
    bus(1, OA, 32'hffffffff);
    bus(0, OA, 32'h0);
    chk("option read", 32'h7, q);
    i_byteenable <= 4'he;
    bus(1, OA, 32'h0);
    i_byteenable <= 4'hf;
    chk("option port", 32'h7, {29'h0, o_option});
    bus(1, OA + 32'h4, 32'hffffffff);
    bus(0, OA + 32'h4, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask
  // reset in mid-run returns the option word to zero
  task automatic t_reset();
    bus(1, OA, 32'h7);
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    chk("wait in reset", 32'h1, {31'h0, o_waitrequest});
    bus(0, OA, 32'h0);
    chk("option after reset", 32'h0, q);
  endtask
  task automatic t_control();
    for (int o = 0; o < 8; o++) begin
      bus(1, OA, o);
      for (int c = 0; c < 32; c++) begin
        @(posedge i_clock);
        i_context <= c[4:0];
        repeat (4) @(posedge i_clock);
        ce = {c[4] && (!c[3] || o[2]), c[4] && (!c[2] || o[1]),
          c[0] && (o[0] || !c[1])};
        @(negedge i_clock);
        chk("control", {29'h0, ce}, {29'h0, o_control});
      end
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    i_rst = 1'b1;
    {i_read, i_write, i_address, i_writedata} = '0;
    i_byteenable = 4'hf;
    i_analog_off = '0;
    i_context = '0;
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs();
    t_reset();
    t_control();
    finish_test();
  end
  initial begin
    repeat (8000) @(posedge i_clock);
    miscompares++;
    finish_test();
  end
endmodule // tb_top
